// [rtl/ccs_defs.svh]
// Purpose: offsets, field positions and reset values of the cascade select block
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   included by bare name
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CCS_OFF_CTRL       8'h00
`define CCS_OFF_TSEL       8'h04
`define CCS_OFF_PAGE       8'h08
`define CCS_OFF_STATUS     8'h0C

// ****************************************************************
// control fields, shared by the bus and by host control writes
// ****************************************************************
`define CCS_CTRL_ENH       0
`define CCS_CTRL_MF_EN     1
`define CCS_CTRL_CMP_MASK  2
`define CCS_CTRL_RESET     3'h2

// ****************************************************************
// status fields
// ****************************************************************
`define CCS_ST_LOCKED      0
`define CCS_ST_TOP         1
`define CCS_ST_FIRST_EMPTY 2
`define CCS_ST_FORCED_FULL 3
`define CCS_ST_IN_CYCLE    4

// ****************************************************************
// select values
// ****************************************************************
`define CCS_TSEL_ALL       16'hFFFF
`define CCS_TSEL_RESET     16'hFFFF
`define CCS_PAGE_RESET     16'h0000

`endif

// [rtl/ccs_pkg.sv]
// Purpose: types shared by the cascade select block
// Assumes: nothing
// Notes:   constants live in ccs_defs.svh
package ccs_pkg;

  // host operation, already decoded from the instruction stream
  typedef enum logic [3:0] {
    CCS_OP_NONE       = 4'h0,
    CCS_OP_TSEL_WR    = 4'h1,
    CCS_OP_PAGE_WR    = 4'h2,
    CCS_OP_FORCE_FULL = 4'h3,
    CCS_OP_CTRL_WR    = 4'h4,
    CCS_OP_SOFT_RESET = 4'h5,
    CCS_OP_MOVE       = 4'h6,
    CCS_OP_VBC        = 4'h7,
    CCS_OP_CMP        = 4'h8,
    CCS_OP_NF_TARGET  = 4'h9,
    CCS_OP_CMPD_WR    = 4'hA,
    CCS_OP_OTHER      = 4'hB
  } ccs_op_t;

  typedef enum logic [1:0] {
    CCS_LOC_OTHER = 2'h0,
    CCS_LOC_NF    = 2'h1,
    CCS_LOC_HM    = 2'h2
  } ccs_loc_t;

  typedef enum logic [1:0] {
    CCS_COND_VALID  = 2'h0,
    CCS_COND_RANDOM = 2'h1,
    CCS_COND_SKIP   = 2'h2,
    CCS_COND_EMPTY  = 2'h3
  } ccs_cond_t;

  typedef struct packed {
    logic      is_cmd;
    logic      is_write;
    ccs_op_t   op;
    ccs_loc_t  loc;
    ccs_cond_t cond;
    logic      seg_end;
    logic      set_valid;
    logic [15:0] data;
  } ccs_cycle_t;

  typedef struct packed {
    ccs_cond_t cond;
    logic      mask_all;
    logic      use_ctrl_mask;
  } ccs_compare_t;

  typedef enum logic [1:0] {
    CCS_ST_IDLE   = 2'b01,
    CCS_ST_ACTIVE = 2'b10
  } ccs_frame_state_t;

endpackage

// [rtl/ccs_frame.sv]
// Purpose: frames host cycles on the cycle strobe and keeps the lock state
// Assumes: strobe and chain enable are synchronous to clock_i
// Notes:   lock state only moves on the rising strobe edge
`timescale 1ns/100ps
`default_nettype none
module ccs_frame (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               strobe_n_i,
  input  wire logic               chain_enable_n_i,
  input  wire ccs_pkg::ccs_cycle_t cycle_i,
  output logic                    start_o,
  output logic                    end_o,
  output logic                    in_cycle_o,
  output ccs_pkg::ccs_cycle_t     cycle_o,
  output logic                    lock_o
);
  ccs_pkg::ccs_frame_state_t state;
  logic                      strobe_q;
  logic                      ec_latched;

  assign start_o    = strobe_q & ~strobe_n_i;
  assign end_o      = ~strobe_q & strobe_n_i;
  assign in_cycle_o = (state == ccs_pkg::CCS_ST_ACTIVE);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= strobe_n_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ccs_pkg::CCS_ST_IDLE;
    end else begin
      case (state)
        ccs_pkg::CCS_ST_IDLE: begin
          if (start_o) begin
            state <= ccs_pkg::CCS_ST_ACTIVE;
          end
        end
        ccs_pkg::CCS_ST_ACTIVE: begin
          if (end_o) begin
            state <= ccs_pkg::CCS_ST_IDLE;
          end
        end
        default: begin
          state <= ccs_pkg::CCS_ST_IDLE;
        end
      endcase
    end
  end

  // falling edge latches chain enable and the cycle, rising edge locks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ec_latched <= 1'b1;
      cycle_o    <= '0;
      lock_o     <= 1'b0;
    end else begin
      if (start_o) begin
        ec_latched <= chain_enable_n_i; // [RULE18]
        cycle_o    <= cycle_i;
      end
      if (end_o) begin
        lock_o <= ~ec_latched; // [RULE18]
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/ccs_select.sv]
// Purpose: device select, chain lock and compare trigger of one cascaded CAM
// Assumes: host cycle already decoded into ccs_cycle_t; registers on AHB-Lite
// Notes:   zero wait state slave, response always OKAY
//
// What this block does
// [RULE1] a target-select write is taken by every device, locked or not
// [RULE2] page writes and force-full only where full-in low and full-out high
// [RULE3] match-out disabled forces internal local match high, no top-match case
// [RULE4] next-free moves and destination writes refused when full-in high or full
// [RULE5] command read after target-next-free answered only by first-empty device; the block does so only while locked
// [RULE6] enhanced locked: top-match moves, validity changes, writes only in top device
// [RULE7] standard no-match keeps data outputs off; host unlocks with idle cycle
// [RULE8] enhanced mode takes writes after a miss without unlocking first
// [RULE9] comparand or mask write at segment end compares against valid locations
// [RULE10] control write other than soft reset runs a compare
// [RULE11] forced compare against empty masks all 64 data bits
// [RULE12] other forced compares use only the control-selected mask
// [RULE13] target-select all ones lets every device take command and data writes
// [RULE14] host picks one device by page identity, restores all ones afterwards
// [RULE15] only the highest-priority matching device acts on top-match location
// [RULE16] chain outputs of last device report full and match of whole string
// [RULE17] standard locked: only match-in high, match-out low device answers
// [RULE18] chain enable latched at strobe fall, lock state set at strobe rise
// [RULE19] first low chain-enable cycle goes to all; later cycles stay locked
// [RULE20] standard unlocking cycle acts only in top-match device, else just unlocks; enhanced also takes writes elsewhere
// [RULE21] enhanced locked: writes everywhere, no reads, next-free only first-empty
// [RULE22] move comparand to next free with valid marks the new entry valid
// [RULE23] target-select all ones refuses reads except in the matching device
// [RULE24] unlocked device selected by neither value ignores every cycle but target-select, page and force-full writes
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defs.svh"
module ccs_select #(
  parameter int DATA_W = 16
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // host cycle port
  input  wire logic                 strobe_n_i,
  input  wire logic                 chain_enable_n_i,
  input  wire ccs_pkg::ccs_cycle_t  cycle_i,
  // chain flags
  input  wire logic                 match_chain_in_n_i,
  input  wire logic                 full_chain_in_n_i,
  input  wire logic                 local_match_flag_n_i,
  input  wire logic                 local_full_i,
  output logic                      match_chain_out_n_o,
  output logic                      full_chain_out_n_o,
  // towards the array
  output logic                      exec_o,
  output ccs_pkg::ccs_cycle_t       exec_cycle_o,
  output logic                      mark_valid_o,
  output logic                      compare_start_o,
  output ccs_pkg::ccs_compare_t     compare_o,
  output logic                      data_out_en_n_o,
  // AHB-Lite slave
  input  wire logic                 hsel_i,
  input  wire logic [7:0]           haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  output logic [31:0]               hrdata_o
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (DATA_W != 16) begin : g_bad_width
    $error("ccs_select: host data path must be 16 bits");
  end

  // ****************************************************************
  // framing and lock state
  // ****************************************************************
  logic                start;
  logic                cyc_end;
  logic                in_cycle;
  logic                locked;
  ccs_pkg::ccs_cycle_t cyc;

  ccs_frame u_frame (
    .clock_i          (clock_i),
    .rst_i            (rst_i),
    .strobe_n_i       (strobe_n_i),
    .chain_enable_n_i (chain_enable_n_i),
    .cycle_i          (cycle_i),
    .start_o          (start),
    .end_o            (cyc_end),
    .in_cycle_o       (in_cycle),
    .cycle_o          (cyc),
    .lock_o           (locked)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [2:0]  ctrl;
  logic [15:0] target_select_reg;
  logic [15:0] page_identity_reg;
  logic        forced_full;
  logic        nf_read_armed;

  logic enhanced;
  logic mf_enable;
  assign enhanced  = ctrl[`CCS_CTRL_ENH];
  assign mf_enable = ctrl[`CCS_CTRL_MF_EN];

  // ****************************************************************
  // chain flags
  // ****************************************************************
  logic ma_int_n;
  logic full_here;
  logic top_match;
  logic first_empty;

  assign ma_int_n    = local_match_flag_n_i | ~mf_enable; // [RULE3]
  assign full_here   = local_full_i | forced_full;
  // low-active outputs merge this device into the string state
  assign match_chain_out_n_o = match_chain_in_n_i & ma_int_n; // [RULE16]
  assign full_chain_out_n_o  = full_chain_in_n_i | ~full_here; // [RULE16]
  assign top_match   = match_chain_in_n_i & ~ma_int_n; // [RULE15]
  assign first_empty = ~full_chain_in_n_i & full_chain_out_n_o;

  // ****************************************************************
  // select decision
  // ****************************************************************
  // next-free work only in the first empty device of the string
  function automatic logic nf_blocked(input ccs_pkg::ccs_cycle_t c, input logic fe);
    nf_blocked = (c.loc == ccs_pkg::CCS_LOC_NF) &&
                 ((c.op == ccs_pkg::CCS_OP_MOVE) || !c.is_cmd) && !fe;
  endfunction

  // top-match moves, validity changes and destination writes
  function automatic logic hm_op(input ccs_pkg::ccs_cycle_t c);
    hm_op = (c.loc == ccs_pkg::CCS_LOC_HM) &&
            ((c.op == ccs_pkg::CCS_OP_MOVE) || (c.op == ccs_pkg::CCS_OP_VBC) || !c.is_cmd);
  endfunction

  logic accept;
  logic tsel_all;
  logic tsel_me;

  assign tsel_all = (target_select_reg == `CCS_TSEL_ALL);
  assign tsel_me  = (target_select_reg == page_identity_reg);

  always_comb begin
    accept = 1'b0;
    if (cyc.is_cmd && cyc.is_write && (cyc.op == ccs_pkg::CCS_OP_TSEL_WR)) begin
      accept = 1'b1; // [RULE1]
    end else if (cyc.is_cmd && cyc.is_write &&
                 ((cyc.op == ccs_pkg::CCS_OP_PAGE_WR) ||
                  (cyc.op == ccs_pkg::CCS_OP_FORCE_FULL))) begin
      accept = first_empty; // [RULE2]
    end else if (!locked) begin
      if (tsel_me) begin
        accept = 1'b1; // [RULE14]
      end else if (tsel_all) begin
        // global writes, reads only from the device that holds the match
        accept = cyc.is_write | top_match; // [RULE13] [RULE23] [RULE19]
      end else begin
        accept = 1'b0; // [RULE24]
      end
    end else if (cyc.is_cmd && !cyc.is_write && nf_read_armed) begin
      accept = first_empty; // [RULE5]
    end else if (top_match) begin
      // also covers the unlocking cycle: in standard mode only the top device acts
      accept = 1'b1; // [RULE17] [RULE20]
    end else if (enhanced) begin
      accept = cyc.is_write && !hm_op(cyc); // [RULE21] [RULE6] [RULE8]
    end else begin
      accept = 1'b0; // [RULE17] [RULE7]
    end
    if (cyc.is_write && nf_blocked(cyc, first_empty)) begin
      accept = 1'b0; // [RULE4] [RULE21]
    end
  end

  // ****************************************************************
  // execution strobe, one cycle after the strobe fall
  // ****************************************************************
  logic start_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start;
    end
  end

  logic exec_now;
  assign exec_now = start_q & accept;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      exec_o       <= 1'b0;
      exec_cycle_o <= '0;
      mark_valid_o <= 1'b0;
    end else begin
      exec_o       <= exec_now;
      if (exec_now) begin
        exec_cycle_o <= cyc;
      end
      mark_valid_o <= exec_now && (cyc.op == ccs_pkg::CCS_OP_MOVE) &&
                      (cyc.loc == ccs_pkg::CCS_LOC_NF) && cyc.set_valid; // [RULE22]
    end
  end

  // output buffers stay off unless this device answers a read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_out_en_n_o <= 1'b1;
    end else if (exec_now && !cyc.is_write) begin
      data_out_en_n_o <= 1'b0;
    end else if (cyc_end || !in_cycle) begin
      data_out_en_n_o <= 1'b1; // [RULE7]
    end
  end

  // a command read right after a target-next-free is routed by the full chain while locked
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      nf_read_armed <= 1'b0;
    end else if (exec_now) begin
      nf_read_armed <= cyc.is_cmd && cyc.is_write &&
                       (cyc.op == ccs_pkg::CCS_OP_NF_TARGET); // [RULE5]
    end else if (start_q) begin
      nf_read_armed <= 1'b0;
    end
  end

  // ****************************************************************
  // compare trigger
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      compare_start_o <= 1'b0;
      compare_o       <= '0;
    end else begin
      compare_start_o <= 1'b0;
      if (exec_now && cyc.is_write) begin
        if (!cyc.is_cmd && (cyc.op == ccs_pkg::CCS_OP_CMPD_WR) && cyc.seg_end) begin
          compare_start_o         <= 1'b1; // [RULE9]
          compare_o.cond          <= ccs_pkg::CCS_COND_VALID;
          compare_o.mask_all      <= 1'b0;
          compare_o.use_ctrl_mask <= ctrl[`CCS_CTRL_CMP_MASK];
        end else if (cyc.is_cmd && (cyc.op == ccs_pkg::CCS_OP_CTRL_WR)) begin
          // compare runs with the settings just written
          compare_start_o         <= 1'b1; // [RULE10]
          compare_o.cond          <= ccs_pkg::CCS_COND_VALID;
          compare_o.mask_all      <= 1'b0;
          compare_o.use_ctrl_mask <= cyc.data[`CCS_CTRL_CMP_MASK];
        end else if (cyc.is_cmd && (cyc.op == ccs_pkg::CCS_OP_CMP)) begin
          compare_start_o         <= 1'b1;
          compare_o.cond          <= cyc.cond;
          if (cyc.cond == ccs_pkg::CCS_COND_EMPTY) begin
            compare_o.mask_all      <= 1'b1; // [RULE11]
            compare_o.use_ctrl_mask <= 1'b0;
          end else begin
            compare_o.mask_all      <= 1'b0; // [RULE12]
            compare_o.use_ctrl_mask <= ctrl[`CCS_CTRL_CMP_MASK];
          end
        end
      end
    end
  end

  // ****************************************************************
  // AHB-Lite slave: address phase captured, data phase completes
  // ****************************************************************
  logic       wr_pend;
  logic [7:0] wr_addr;

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  logic take;
  assign take = hsel_i & hready_i & htrans_i[1];

  logic bus_wr;
  assign bus_wr = wr_pend;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take & hwrite_i & (hsize_i == 3'h2);
      wr_addr <= haddr_i;
    end
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      if (haddr_i == `CCS_OFF_CTRL) begin
        hrdata_o <= {29'h0000_0000, ctrl};
      end else if (haddr_i == `CCS_OFF_TSEL) begin
        hrdata_o <= {16'h0000, target_select_reg};
      end else if (haddr_i == `CCS_OFF_PAGE) begin
        hrdata_o <= {16'h0000, page_identity_reg};
      end else if (haddr_i == `CCS_OFF_STATUS) begin
        hrdata_o <= {27'h0000_000, in_cycle, forced_full, first_empty, top_match, locked};
      end else begin
        hrdata_o <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // register updates: bus writes and accepted host commands
  // ****************************************************************
  logic host_cmd_wr;
  assign host_cmd_wr = exec_now & cyc.is_cmd & cyc.is_write;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl <= `CCS_CTRL_RESET;
    end else if (host_cmd_wr && (cyc.op == ccs_pkg::CCS_OP_SOFT_RESET)) begin
      ctrl <= `CCS_CTRL_RESET;
    end else if (host_cmd_wr && (cyc.op == ccs_pkg::CCS_OP_CTRL_WR)) begin
      ctrl <= cyc.data[2:0];
    end else if (bus_wr && (wr_addr == `CCS_OFF_CTRL)) begin
      ctrl <= hwdata_i[2:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      target_select_reg <= `CCS_TSEL_RESET;
    end else if (host_cmd_wr && (cyc.op == ccs_pkg::CCS_OP_TSEL_WR)) begin
      target_select_reg <= cyc.data; // [RULE1]
    end else if (bus_wr && (wr_addr == `CCS_OFF_TSEL)) begin
      target_select_reg <= hwdata_i[15:0];
    end
  end

  // page identity survives a soft reset; bus can only read it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      page_identity_reg <= `CCS_PAGE_RESET;
    end else if (host_cmd_wr && (cyc.op == ccs_pkg::CCS_OP_PAGE_WR)) begin
      page_identity_reg <= cyc.data; // [RULE2]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      forced_full <= 1'b0;
    end else if (host_cmd_wr && (cyc.op == ccs_pkg::CCS_OP_FORCE_FULL)) begin
      forced_full <= 1'b1; // [RULE2]
    end else if (host_cmd_wr && (cyc.op == ccs_pkg::CCS_OP_SOFT_RESET)) begin
      forced_full <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [testbench/ccs_chain_peer.sv]
// Purpose: upper neighbour device on the match and full chains
// Assumes: neighbour flags settle within one clock
// Notes:   the bench steers it through hit_i and full_i
`timescale 1ns/100ps
`default_nettype none
module ccs_chain_peer (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic hit_i,
  input  wire logic full_i,
  output logic      match_n_o,
  output logic      full_n_o
);
  // a freshly reset chain is empty and has no match
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      match_n_o <= 1'b1;
      full_n_o  <= 1'b1;
    end else begin
      match_n_o <= ~hit_i;
      full_n_o  <= ~full_i;
    end
  end
endmodule
`default_nettype wire

// [testbench/ccs_select_properties.sv]
// Purpose: port-level checks of the cascade select block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every ccs_select instance
`timescale 1ns/100ps
`default_nettype none
module ccs_select_properties (
  input wire logic                  clock_i,
  input wire logic                  rst_i,
  input wire logic                  strobe_n_i,
  input wire ccs_pkg::ccs_cycle_t   cycle_i,
  input wire logic                  match_chain_in_n_i,
  input wire logic                  full_chain_in_n_i,
  input wire logic                  match_chain_out_n_o,
  input wire logic                  full_chain_out_n_o,
  input wire logic                  exec_o,
  input wire ccs_pkg::ccs_cycle_t   exec_cycle_o,
  input wire logic                  mark_valid_o,
  input wire logic                  compare_start_o,
  input wire ccs_pkg::ccs_compare_t compare_o,
  input wire logic                  data_out_en_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  tsel_take_a: assert property ($fell(strobe_n_i) && cycle_i.is_write
    && cycle_i.op == ccs_pkg::CCS_OP_TSEL_WR |-> ##[2:3] exec_o) else $error("tsel write lost");
  match_chain_a: assert property (!match_chain_in_n_i |-> !match_chain_out_n_o)
    else $error("match chain broken");
  full_chain_a: assert property (full_chain_in_n_i |-> full_chain_out_n_o)
    else $error("full chain broken");
  mark_valid_a: assert property (mark_valid_o |-> exec_o && exec_cycle_o.set_valid
    && exec_cycle_o.loc == ccs_pkg::CCS_LOC_NF) else $error("stray valid mark");
  empty_mask_a: assert property (compare_start_o
    && compare_o.cond == ccs_pkg::CCS_COND_EMPTY |-> compare_o.mask_all) else $error("no mask");
  ctrl_mask_a: assert property (compare_start_o
    && compare_o.cond != ccs_pkg::CCS_COND_EMPTY |-> !compare_o.mask_all) else $error("mask");
  exec_pulse_a: assert property (exec_o |=> !exec_o [*3])
    else $error("exec too long");
  ctrl_cmp_a: assert property (exec_o && exec_cycle_o.op == ccs_pkg::CCS_OP_CTRL_WR
    |-> compare_start_o) else $error("no compare after control write");
  seg_cmp_a: assert property (exec_o && exec_cycle_o.seg_end
    && exec_cycle_o.op == ccs_pkg::CCS_OP_CMPD_WR |-> compare_start_o) else $error("no compare");
  read_drive_a: assert property ($fell(data_out_en_n_o) |-> exec_o
    && !exec_cycle_o.is_write) else $error("output on without read");
endmodule
bind ccs_select ccs_select_properties u_props (.clock_i(clock_i), .rst_i(rst_i),
  .strobe_n_i(strobe_n_i), .cycle_i(cycle_i), .match_chain_in_n_i(match_chain_in_n_i),
  .full_chain_in_n_i(full_chain_in_n_i), .match_chain_out_n_o(match_chain_out_n_o),
  .full_chain_out_n_o(full_chain_out_n_o), .exec_o(exec_o), .exec_cycle_o(exec_cycle_o),
  .mark_valid_o(mark_valid_o), .compare_start_o(compare_start_o), .compare_o(compare_o),
  .data_out_en_n_o(data_out_en_n_o));
`default_nettype wire

// [testbench/ccs_select_tb.sv]
// Purpose: self-checking bench of the cascade select block
// Assumes: bench is the host and the array; peer is the upper neighbour
// Notes:   op codes in rows follow ccs_op_t
`timescale 1ns/100ps
`default_nettype none
module ccs_select_tb;
  typedef struct {ccs_pkg::ccs_cycle_t c; logic f; logic xe; logic xc;} ccs_row_t;
  logic clock_i, rst_i, stb_n, ec_n, min_n, fin_n, lm_n, lf, hit, ful;
  logic mout_n, fout_n, ex, mv, cs, oe_n, hro, hresp, hsel, hwr, sx, sc, sm, sv, so;
  ccs_pkg::ccs_cycle_t cyc, xcyc;
  ccs_pkg::ccs_compare_t cmp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwd, hrd, rd;
  int err_count, n_tests, tmo;
  ccs_row_t rows [15];
  ccs_chain_peer u_peer (.clock_i(clock_i), .rst_i(rst_i), .hit_i(hit), .full_i(ful),
    .match_n_o(min_n), .full_n_o(fin_n));
  ccs_select u_dut (.clock_i(clock_i), .rst_i(rst_i), .strobe_n_i(stb_n),
    .chain_enable_n_i(ec_n), .cycle_i(cyc), .match_chain_in_n_i(min_n),
    .full_chain_in_n_i(fin_n), .local_match_flag_n_i(lm_n), .local_full_i(lf),
    .match_chain_out_n_o(mout_n), .full_chain_out_n_o(fout_n), .exec_o(ex),
    .exec_cycle_o(xcyc), .mark_valid_o(mv), .compare_start_o(cs), .compare_o(cmp),
    .data_out_en_n_o(oe_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hro), .hreadyout_o(hro),
    .hresp_o(hresp), .hrdata_o(hrd));
  // ****
  // shared tasks
  // ****
  function automatic ccs_pkg::ccs_cycle_t cy(logic [3:0] op, logic w, logic [1:0] l,
                                             logic [1:0] k);
    cy = '{op != 4'hA, w, ccs_pkg::ccs_op_t'(op), ccs_pkg::ccs_loc_t'(l),
           ccs_pkg::ccs_cond_t'(k), 1'b1, 1'b1, 16'h0002};
  endfunction
  task chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock_i);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwr <= w;
    do @(posedge clock_i); while (hro !== 1'b1);
    htrans <= 2'b00; hwd <= d;
    do @(posedge clock_i); while (hro !== 1'b1);
    rd = hrd;
    hsel <= 1'b0;
  endtask
  // one framed host cycle; outputs are sampled at falling edges, clear of updates
  task hc(ccs_pkg::ccs_cycle_t c, logic e, logic xe);
    @(posedge clock_i);
    stb_n <= 1'b0; cyc <= c; ec_n <= e;
    {sx, sc, sm, sv, so} = '0;
    repeat (4) begin
      @(negedge clock_i);
      sx |= ex; sc |= cs; sm |= cs & cmp.mask_all; sv |= mv; so |= ~oe_n;
    end
    @(posedge clock_i);
    stb_n <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(sx, xe);
    if (xe) chk(xcyc, c);
  endtask
  task wrap_up;
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clock_i = 0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    tmo++;
    if (tmo > 20000) begin
      err_count++;
      wrap_up();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    {rst_i, stb_n, ec_n, lm_n} = 4'hF;
    {lf, hit, ful, hsel, hwr} = '0;
    cyc = '0; haddr = '0; htrans = '0; hwd = '0;
    err_count = 0; n_tests = 0; tmo = 0;
    rows = '{'{cy(4,1,0,0),0,1,1}, '{cy(5,1,0,0),0,1,0}, '{cy(10,1,0,0),0,1,1},
      '{cy(8,1,0,3),0,1,1}, '{cy(8,1,0,0),0,1,1}, '{cy(8,1,0,1),0,1,1},
      '{cy(8,1,0,2),0,1,1}, '{cy(11,0,0,0),0,0,0}, '{cy(2,1,0,0),0,0,0},
      '{cy(2,1,0,0),1,1,0}, '{cy(3,1,0,0),1,1,0}, '{cy(6,1,1,0),1,0,0},
      '{cy(5,1,0,0),1,1,0}, '{cy(6,1,1,0),1,1,0}, '{cy(6,1,1,0),0,0,0}};
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    bus(0, 8'h00, 0); chk(rd, 32'h0000_0002);
    chk(hresp, 1'b0);
    bus(0, 8'h04, 0); chk(rd, 32'h0000_FFFF);
    bus(1, 8'h08, 32'h0000_0055); bus(0, 8'h08, 0); chk(rd, 32'h0000_0000);
    bus(0, 8'h10, 0); chk(rd, 32'h0000_0000);
    foreach (rows[i]) begin
      ful <= rows[i].f;
      hc(rows[i].c, 1'b1, rows[i].xe);
      chk(sc, rows[i].xc);
      chk(sm, rows[i].c.cond == ccs_pkg::CCS_COND_EMPTY && rows[i].xc);
      chk(sv, rows[i].xe && rows[i].c.op == ccs_pkg::CCS_OP_MOVE);
      if (rows[i].xc) chk(cmp.cond, rows[i].c.cond);
    end
    ful <= 1'b0;
    bus(1, 8'h04, 32'h0000_0005);
    hc(cy(4,1,0,0), 1'b1, 1'b0);
    hc(cy(1,1,0,0), 1'b1, 1'b1);
    hc(cy(11,0,0,0), 1'b1, 1'b1); chk(so, 1'b1);
    bus(1, 8'h04, 32'h0000_FFFF);
    hc(cy(4,1,0,0), 1'b0, 1'b1);
    hc(cy(11,1,0,0), 1'b0, 1'b0);
    hc(cy(11,0,0,0), 1'b0, 1'b0); chk(so, 1'b0);
    lm_n <= 1'b0;
    hc(cy(11,0,0,0), 1'b0, 1'b1); chk(so, 1'b1);
    hc(cy(11,1,0,0), 1'b1, 1'b1);
    lm_n <= 1'b1;
    hc(cy(11,1,0,0), 1'b0, 1'b1);
    hc(cy(11,1,0,0), 1'b1, 1'b0);
    hc(cy(11,1,0,0), 1'b1, 1'b1);
    bus(1, 8'h00, 32'h0000_0003);
    hc(cy(11,1,0,0), 1'b0, 1'b1);
    hc(cy(11,1,0,0), 1'b0, 1'b1);
    hc(cy(11,0,0,0), 1'b0, 1'b0);
    hc(cy(7,1,2,0), 1'b0, 1'b0);
    ful <= 1'b1;
    hc(cy(6,1,1,0), 1'b0, 1'b1);
    hc(cy(9,1,0,0), 1'b0, 1'b1);
    hc(cy(11,0,0,0), 1'b0, 1'b1); chk(so, 1'b1);
    hc(cy(11,1,0,0), 1'b1, 1'b1);
    {hit, lm_n, ful} <= 3'b100;
    repeat (3) @(posedge clock_i);
    chk(mout_n, 1'b0);
    chk(fout_n, 1'b1);
    {hit, lm_n, ful, lf} <= 4'b0011;
    repeat (3) @(posedge clock_i);
    chk(mout_n, 1'b0);
    chk(fout_n, 1'b0);
    bus(1, 8'h00, 32'h0000_0000);
    repeat (3) @(posedge clock_i);
    chk(mout_n, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
